// File: verilog/pos_tx_stats_counters.sv
`timescale 1ns/100ps
`include "pos_tx_stats_defs.svh"
module pos_tx_stats_counters (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output pos_tx_stats_pkg::reg_word_t regRdData,
   output logic regRdValid,
   input wire logic fetchReq,
   input wire logic fifoEmpty,
   input wire logic fifoSop,
   input wire logic fifoEop,
   input wire logic [2:0] fifoByteCount,
   input wire logic link_transmit_error_input,
   input wire logic crcErrorInsert,
   output logic abortSeq,
   output logic frameSent,
   output logic discarding,
   output logic [6:0] tx_event_enable
);
   pos_tx_stats_pkg::pkt_state_t state;
   pos_tx_stats_pkg::pkt_state_t next_state;
   logic [6:0] tx_event_status;
   logic [6:0] next_status;
   logic [6:0] next_enable;
   logic [6:0] statusSet;
   pos_tx_stats_pkg::reg_word_t next_rdData;
   logic next_abortSeq;
   logic next_frameSent;
   logic wordTaken;
   logic startWord;
   logic inPktWord;
   logic underflow;
   logic linkAbort;
   logic goodEnd;
   logic statusRead;
   logic [3:0] cntInc;
   logic [3:0] capture;
   logic [3:0] wrapPulse;
   logic [31:0] held [0:3];
   logic [2:0] cntAmount [0:3];

   // Width of each counter, frame, byte, link abort and underrun abort in that order.
   function automatic int cntWidth(input int idx);
      case (idx)
         0: cntWidth = `FRAME_CNT_W;
         1: cntWidth = `BYTE_CNT_W;
         2: cntWidth = `LINK_CNT_W;
         default: cntWidth = `UNDERRUN_CNT_W;
      endcase
   endfunction

   // Maps a counter address to its counter index.
   function automatic logic [1:0] cntIndex(input logic [7:0] addr);
      logic [7:0] off;
      off = addr - `ADDR_FRAME_LO;
      cntIndex = off[2:1];
   endfunction

   // True for the addresses whose write captures and clears a counter.
   function automatic logic isCaptureAddr(input logic [7:0] addr);
      isCaptureAddr = (addr == `ADDR_FRAME_HI) || (addr == `ADDR_BYTE_HI) ||
                      (addr == `ADDR_LINK_HI) || (addr == `ADDR_UNDERRUN);
   endfunction

   // Classification of the current FIFO fetch.
   always_comb
   begin
      wordTaken = fetchReq & ~fifoEmpty;
      startWord = wordTaken & fifoSop & (state != pos_tx_stats_pkg::PKT_ACTIVE);
      inPktWord = (wordTaken & (state == pos_tx_stats_pkg::PKT_ACTIVE)) | startWord;
      underflow = fetchReq & fifoEmpty & (state == pos_tx_stats_pkg::PKT_ACTIVE);
      linkAbort = inPktWord & fifoEop & link_transmit_error_input;
      goodEnd = inPktWord & fifoEop & ~link_transmit_error_input;
   end

   // Packet walk, abort sequence and frame completion.
   always_comb
   begin
      next_state = state;
      if (underflow)
      begin
         next_state = pos_tx_stats_pkg::PKT_DISCARD;
      end
      else if (inPktWord)
      begin
         next_state = fifoEop ? pos_tx_stats_pkg::PKT_IDLE : pos_tx_stats_pkg::PKT_ACTIVE;
      end
      next_abortSeq = linkAbort | underflow;
      next_frameSent = goodEnd;
   end

   // Packet walk registers.
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         state <= pos_tx_stats_pkg::PKT_IDLE;
         abortSeq <= 1'b0;
         frameSent <= 1'b0;
         discarding <= 1'b0;
      end
      else
      begin
         state <= next_state;
         abortSeq <= next_abortSeq;
         frameSent <= next_frameSent;
         discarding <= (next_state == pos_tx_stats_pkg::PKT_DISCARD);
      end
   end

   // Count events and amounts fed to the four statistics counters.
   always_comb
   begin
      cntInc[0] = goodEnd;
      cntInc[1] = inPktWord;
      cntInc[2] = linkAbort;
      cntInc[3] = underflow;
      cntAmount[0] = 3'h1;
      cntAmount[1] = fifoByteCount;
      cntAmount[2] = 3'h1;
      cntAmount[3] = 3'h1;
   end

   // One counter with capture buffer per statistic.
   genvar gi;
   generate
      for (gi = 0; gi < `NUM_COUNTERS; gi = gi + 1)
      begin : g_cnt
         assign capture[gi] = regWrEn & isCaptureAddr(regAddr) &
                              (cntIndex(regAddr) == 2'(gi));
         stat_counter #(
            .W(cntWidth(gi))
         ) u_cnt (
            .ref_clk(ref_clk),
            .resetn(resetn),
            .inc(cntInc[gi]),
            .amount(cntAmount[gi]),
            .capture(capture[gi]),
            .held(held[gi]),
            .wrapped(wrapPulse[gi])
         );
      end
   endgenerate

   // Event flags are sticky; a new event in the read cycle survives the clear.
   always_comb
   begin
      statusRead = regRdEn & (regAddr == `ADDR_STATUS);
      statusSet = 7'h00;
      statusSet[`BIT_BYTE_WRAP] = wrapPulse[1];
      statusSet[`BIT_FRAME_WRAP] = wrapPulse[0];
      statusSet[`BIT_LINK_WRAP] = wrapPulse[2];
      statusSet[`BIT_UNDERRUN_WRAP] = wrapPulse[3];
      statusSet[`BIT_LINK_ABORT] = linkAbort;
      statusSet[`BIT_CRC_INSERT] = crcErrorInsert;
      statusSet[`BIT_UNDERFLOW] = underflow;
      next_status = (statusRead ? 7'h00 : tx_event_status) | statusSet;
      next_enable = tx_event_enable;
      if (regWrEn && regAddr == `ADDR_ENABLE)
      begin
         next_enable = regWrData[6:0];
      end
   end

   // Read data mux; counters return their captured buffers.
   always_comb
   begin
      next_rdData = 16'h0000;
      case (regAddr)
         `ADDR_FRAME_LO: next_rdData = held[0][15:0];
         `ADDR_FRAME_HI: next_rdData = {5'h00, held[0][26:16]};
         `ADDR_BYTE_LO: next_rdData = held[1][15:0];
         `ADDR_BYTE_HI: next_rdData = held[1][31:16];
         `ADDR_LINK_LO: next_rdData = held[2][15:0];
         `ADDR_LINK_HI: next_rdData = held[2][31:16];
         `ADDR_UNDERRUN: next_rdData = held[3][15:0];
         `ADDR_STATUS: next_rdData = {9'h000, tx_event_status};
         `ADDR_ENABLE: next_rdData = {9'h000, tx_event_enable};
         default: next_rdData = 16'h0000;
      endcase
   end

   // Register port state.
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         tx_event_status <= `STATUS_RESET;
         tx_event_enable <= `ENABLE_RESET;
         regRdData <= 16'h0000;
         regRdValid <= 1'b0;
      end
      else
      begin
         tx_event_status <= next_status;
         tx_event_enable <= next_enable;
         regRdData <= regRdEn ? next_rdData : regRdData;
         regRdValid <= regRdEn;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   // Frame ends: a good end reports a frame, an aborted one never does.
   a_good_frame: assert property (goodEnd |=> frameSent && !abortSeq)
      else $error("Good frame end not reported.");
   a_abort_no_frame: assert property (linkAbort |=> abortSeq && !frameSent)
      else $error("Link aborted frame counted as sent.");
   a_underrun_no_frame: assert property (underflow |=> !frameSent)
      else $error("Underrun aborted frame counted as sent.");
   a_end_exclusive: assert property (!(frameSent && abortSeq))
      else $error("Frame reported both sent and aborted.");
   a_link_abort_flag: assert property (linkAbort |=> tx_event_status[`BIT_LINK_ABORT])
      else $error("Link abort flag not set.");
   a_abort_cause: assert property (abortSeq
      |-> $past(linkAbort || underflow))
      else $error("Abort sequence without a link abort or underflow.");
   a_link_flag_hold: assert property (!linkAbort && !statusRead
      |=> tx_event_status[`BIT_LINK_ABORT] == $past(tx_event_status[`BIT_LINK_ABORT]))
      else $error("Link abort flag changed without event or read.");

   // Underflow aborts the packet, then words are dropped until a start of packet.
   a_underflow_abort: assert property (underflow
      |=> abortSeq && discarding && tx_event_status[`BIT_UNDERFLOW])
      else $error("Underflow did not abort the packet.");
   a_first_word_empty: assert property (fetchReq && fifoEmpty
      && state != pos_tx_stats_pkg::PKT_ACTIVE |=> !abortSeq)
      else $error("Empty fetch outside a packet aborted a frame.");
   a_discard_hold: assert property (state == pos_tx_stats_pkg::PKT_DISCARD
      && !(wordTaken && fifoSop) |=> discarding)
      else $error("Discard ended without start of packet.");
   a_discard_drop: assert property (state == pos_tx_stats_pkg::PKT_DISCARD
      && wordTaken && !fifoSop |=> !frameSent && !abortSeq)
      else $error("Word dropped in discard produced a frame event.");
   a_sop_resync: assert property (state == pos_tx_stats_pkg::PKT_DISCARD
      && wordTaken && fifoSop |=> !discarding)
      else $error("Start of packet did not end the discard.");
   a_discard_cause: assert property ($rose(discarding) |-> $past(underflow))
      else $error("Discard began without an underflow.");

   // Event flags set on their event and hold until a status read.
   a_status_clear: assert property (statusRead && statusSet == 7'h00
      |=> tx_event_status == 7'h00)
      else $error("Status read did not clear flags.");
   a_status_readback: assert property (statusRead
      |=> regRdData == {9'h000, $past(tx_event_status)})
      else $error("Status read returned wrong flags.");
   a_frame_wrap_flag: assert property (wrapPulse[0]
      |=> tx_event_status[`BIT_FRAME_WRAP])
      else $error("Frame wrap flag not set.");
   a_byte_wrap_flag: assert property (wrapPulse[1]
      |=> tx_event_status[`BIT_BYTE_WRAP])
      else $error("Byte wrap flag not set.");
   a_link_wrap_flag: assert property (wrapPulse[2]
      |=> tx_event_status[`BIT_LINK_WRAP])
      else $error("Link abort wrap flag not set.");
   a_under_wrap_flag: assert property (wrapPulse[3]
      |=> tx_event_status[`BIT_UNDERRUN_WRAP])
      else $error("Underrun wrap flag not set.");
   a_crc_flag: assert property (crcErrorInsert
      |=> tx_event_status[`BIT_CRC_INSERT])
      else $error("FCS insert flag not set.");
   a_crc_hold: assert property (!crcErrorInsert && !statusRead
      |=> tx_event_status[`BIT_CRC_INSERT] == $past(tx_event_status[`BIT_CRC_INSERT]))
      else $error("FCS insert flag changed without event or read.");
   a_underflow_hold: assert property (!underflow && !statusRead
      |=> tx_event_status[`BIT_UNDERFLOW] == $past(tx_event_status[`BIT_UNDERFLOW]))
      else $error("Underflow flag changed without event or read.");

   // Register port: enable writes, read latency and the width of each upper word.
   a_enable_write: assert property (regWrEn && regAddr == `ADDR_ENABLE
      |=> tx_event_enable == $past(regWrData[6:0]))
      else $error("Enable register write lost.");
   a_enable_stable: assert property (!(regWrEn && regAddr == `ADDR_ENABLE)
      |=> $stable(tx_event_enable))
      else $error("Enable register changed without a write.");
   a_read_latency: assert property (regRdEn |=> regRdValid)
      else $error("Read valid missing one cycle after the strobe.");
   a_capture_read: assert property (regRdEn && regAddr == `ADDR_UNDERRUN
      |=> regRdValid && regRdData == held[3][15:0])
      else $error("Underrun count buffer not returned.");
   a_frame_upper: assert property (regRdEn && regAddr == `ADDR_FRAME_HI
      |=> regRdData[15:11] == 5'h00)
      else $error("Frame count upper word has bits above 26.");
   a_byte_upper: assert property (regRdEn && regAddr == `ADDR_BYTE_HI
      |=> regRdData[15:13] == 3'h0)
      else $error("Byte count upper word has bits above 28.");
   a_link_upper: assert property (regRdEn && regAddr == `ADDR_LINK_HI
      |=> regRdData[15:4] == 12'h000)
      else $error("Link abort count upper word has bits above 19.");
   a_unmapped_read: assert property (regRdEn && regAddr > `ADDR_ENABLE
      |=> regRdData == 16'h0000)
      else $error("Unmapped address returned nonzero data.");

   // Main scenarios that the tests are expected to reach.
   c_good_frame: cover property (startWord ##[1:20] goodEnd);
   c_link_abort: cover property (linkAbort);
   c_underflow_resync: cover property (underflow ##[1:40] startWord);
   c_status_read: cover property (statusRead && tx_event_status != 7'h00);
   c_discard_drop: cover property (state == pos_tx_stats_pkg::PKT_DISCARD && wordTaken && !fifoSop);
endmodule

// File: common/pos_tx_stats_defs.svh
`ifndef POS_TX_STATS_DEFS_SVH
`define POS_TX_STATS_DEFS_SVH
`define ADDR_FRAME_LO 8'h42
`define ADDR_FRAME_HI 8'h43
`define ADDR_BYTE_LO 8'h44
`define ADDR_BYTE_HI 8'h45
`define ADDR_LINK_LO 8'h46
`define ADDR_LINK_HI 8'h47
`define ADDR_UNDERRUN 8'h48
`define ADDR_STATUS 8'h49
`define ADDR_ENABLE 8'h4A
`define FRAME_CNT_W 27
`define BYTE_CNT_W 29
`define LINK_CNT_W 20
`define UNDERRUN_CNT_W 16
`define NUM_COUNTERS 4
`define BIT_BYTE_WRAP 6
`define BIT_FRAME_WRAP 5
`define BIT_LINK_WRAP 4
`define BIT_UNDERRUN_WRAP 3
`define BIT_LINK_ABORT 2
`define BIT_CRC_INSERT 1
`define BIT_UNDERFLOW 0
`define EVENT_BITS 7
`define COUNT_RESET 32'h0000_0000
`define STATUS_RESET 7'h00
`define ENABLE_RESET 7'h00
`endif

// File: common/pos_tx_stats_pkg.sv
package pos_tx_stats_pkg;
   // Packet walk states, Gray coded along idle, in packet, discard.
   typedef enum logic [1:0]
   {
      PKT_IDLE = 2'b00,
      PKT_ACTIVE = 2'b01,
      PKT_DISCARD = 2'b11
   } pkt_state_t;
   typedef logic [15:0] reg_word_t;
endpackage

// File: verilog/stat_counter.sv
`timescale 1ns/100ps
`include "pos_tx_stats_defs.svh"
module stat_counter #(
   parameter int W = 16
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic inc,
   input wire logic [2:0] amount,
   input wire logic capture,
   output logic [31:0] held,
   output logic wrapped
);
   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic [31:0] next_held;
   logic next_wrapped;
   logic [W:0] sum;

   // Capture copies the count to the buffer and restarts it; wrap carries out of the top.
   always_comb
   begin
      sum = {1'b0, count} + {{(W - 2){1'b0}}, inc ? amount : 3'h0};
      next_held = held;
      next_count = sum[W-1:0];
      next_wrapped = inc & sum[W];
      if (capture)
      begin
         next_held = 32'(count);
         next_count = W'(inc ? amount : 3'h0);
         next_wrapped = 1'b0;
      end
   end

   // Counter state registers.
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         count <= W'(`COUNT_RESET);
         held <= `COUNT_RESET;
         wrapped <= 1'b0;
      end
      else
      begin
         count <= next_count;
         held <= next_held;
         wrapped <= next_wrapped;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   a_capture_copies: assert property (capture |=> held == 32'($past(count)))
      else $error("Capture did not copy the count.");
   a_wrap_to_zero: assert property (inc && !capture && sum[W] |=> wrapped && count < W'(4))
      else $error("Counter did not wrap to zero.");
endmodule

// File: tb/fifo_feeder.sv
`timescale 1ns/100ps
// Link-layer side: presents transmit FIFO words as the controller fetches them.
module fifo_feeder (
   input wire logic ref_clk,
   output logic fetchReq,
   output logic fifoEmpty,
   output logic fifoSop,
   output logic fifoEop,
   output logic [2:0] fifoByteCount,
   output logic linkErr
);
   // The FIFO starts empty with no fetch in progress.
   initial
   begin
      fetchReq = 1'b0;
      fifoEmpty = 1'b1;
      fifoSop = 1'b0;
      fifoEop = 1'b0;
      fifoByteCount = 3'h0;
      linkErr = 1'b0;
   end
   // Drives every line just after a rising edge.
   task automatic drive(input logic f, input logic m, input logic s, input logic e,
                        input logic [2:0] n, input logic x);
      @(posedge ref_clk);
      #1;
      fetchReq = f;
      fifoEmpty = m;
      fifoSop = s;
      fifoEop = e;
      fifoByteCount = n;
      linkErr = x;
   endtask
   // One valid word; the error line aborts the frame on its last word.
   task automatic word(input logic s, input logic e, input logic [2:0] n, input logic x);
      drive(1'b1, 1'b0, s, e, n, x);
   endtask
   // A fetch from an empty FIFO; the data lines carry stale junk, inverted.
   task automatic gap;
      drive(1'b1, 1'b1, ~fifoSop, ~fifoEop, ~fifoByteCount, 1'b0);
   endtask
   // No fetch; the data lines are inverted so stale values are never trusted.
   task automatic idle;
      drive(1'b0, 1'b1, ~fifoSop, ~fifoEop, ~fifoByteCount, 1'b0);
   endtask
endmodule

// File: tb/test_pos_tx_stats_counters.sv
`timescale 1ns/100ps
module test_pos_tx_stats_counters;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [15:0] regWrData = 16'h0000;
   logic regWrEn = 1'b0;
   logic regRdEn = 1'b0;
   logic crcErrorInsert = 1'b0;
   pos_tx_stats_pkg::reg_word_t regRdData;
   logic regRdValid, fetchReq, fifoEmpty, fifoSop, fifoEop, linkErr;
   logic [2:0] fifoByteCount;
   logic abortSeq, frameSent, discarding;
   logic [6:0] tx_event_enable;
   int fail_count = 0;
   int tests_run = 0;
   int cycles = 0;
   pos_tx_stats_counters DUT (.ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
      .regRdValid(regRdValid), .fetchReq(fetchReq), .fifoEmpty(fifoEmpty),
      .fifoSop(fifoSop), .fifoEop(fifoEop), .fifoByteCount(fifoByteCount),
      .link_transmit_error_input(linkErr), .crcErrorInsert(crcErrorInsert),
      .abortSeq(abortSeq), .frameSent(frameSent), .discarding(discarding),
      .tx_event_enable(tx_event_enable));
   fifo_feeder p (.ref_clk(ref_clk), .fetchReq(fetchReq), .fifoEmpty(fifoEmpty),
      .fifoSop(fifoSop), .fifoEop(fifoEop), .fifoByteCount(fifoByteCount), .linkErr(linkErr));
   // A 100 MHz clock.
   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end
   // Cuts a hang short.
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fail_count++;
         $display("mismatch at %0t: run timed out", $time);
         summarize();
      end
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Compares a seen value with the expected one.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      tests_run++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: %s got %h want %h", $time, msg, seen, exp);
      end
   endtask
   task automatic step;
      @(posedge ref_clk);
      #1;
   endtask
   // One-cycle write strobe.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      step();
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      step();
      regWrEn = 1'b0;
   endtask
   // One-cycle read strobe; data and valid are due one cycle later.
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      step();
      regAddr = a;
      regRdEn = 1'b1;
      step();
      regRdEn = 1'b0;
      check(regRdValid, 1'b1, "read valid");
      check(regRdData, e, $sformatf("read %h", a));
   endtask
   // Every register reads zero after reset; an unmapped address reads zero.
   task automatic t_reset;
      logic [7:0] a;
      for (a = 8'h42; a <= 8'h4A; a++)
         rd(a, 16'h0000);
      rd(8'h50, 16'h0000);
      $display("test reset done");
   endtask
   // Good frames, capture and clear, byte total.
   task automatic t_good;
      p.word(1'b1, 1'b0, 3'h4, 1'b0);
      p.word(1'b0, 1'b1, 3'h3, 1'b0);
      p.idle();
      check(frameSent, 1'b1, "frame sent");
      p.word(1'b1, 1'b1, 3'h2, 1'b0);
      p.idle();
      check(frameSent, 1'b1, "single word frame");
      wr(8'h43, 16'hFFFF);
      rd(8'h42, 16'h0002);
      rd(8'h43, 16'h0000);
      wr(8'h43, 16'h0000);
      rd(8'h42, 16'h0000);
      wr(8'h45, 16'h0000);
      rd(8'h44, 16'h0009);
      rd(8'h45, 16'h0000);
      $display("test good frames done");
   endtask
   // A frame aborted by the link layer.
   task automatic t_link;
      p.word(1'b1, 1'b0, 3'h4, 1'b0);
      p.word(1'b0, 1'b1, 3'h4, 1'b1);
      p.idle();
      check(abortSeq, 1'b1, "link abort sequence");
      check(frameSent, 1'b0, "aborted frame sent");
      rd(8'h49, 16'h0004);
      rd(8'h49, 16'h0000);
      wr(8'h47, 16'h0000);
      rd(8'h46, 16'h0001);
      wr(8'h43, 16'h0000);
      rd(8'h42, 16'h0000);
      wr(8'h45, 16'h0000);
      rd(8'h44, 16'h0008);
      $display("test link abort done");
   endtask
   // Mid-packet underflow, discard until a new start of packet.
   task automatic t_under;
      p.gap();
      p.word(1'b1, 1'b0, 3'h4, 1'b0);
      check(abortSeq, 1'b0, "empty fetch outside packet");
      p.gap();
      p.idle();
      check(abortSeq, 1'b1, "underflow abort");
      check(discarding, 1'b1, "discard after underflow");
      p.word(1'b0, 1'b1, 3'h4, 1'b0);
      p.idle();
      step();
      check(frameSent, 1'b0, "word during discard");
      check(discarding, 1'b1, "still discarding");
      p.word(1'b1, 1'b1, 3'h1, 1'b0);
      p.idle();
      check(discarding, 1'b0, "discard ends at sop");
      check(frameSent, 1'b1, "frame after discard");
      rd(8'h49, 16'h0001);
      wr(8'h48, 16'h0000);
      rd(8'h48, 16'h0001);
      wr(8'h43, 16'h0000);
      rd(8'h42, 16'h0001);
      $display("test underflow done");
   endtask
   // Error insertion flag, enable register, read-only write ignored.
   task automatic t_misc;
      step();
      crcErrorInsert = 1'b1;
      step();
      crcErrorInsert = 1'b0;
      rd(8'h49, 16'h0002);
      wr(8'h4A, 16'h007F);
      rd(8'h4A, 16'h007F);
      check(tx_event_enable, 7'h7F, "enable pins");
      wr(8'h42, 16'hFFFF);
      rd(8'h42, 16'h0001);
      $display("test status and enable done");
   endtask
   // Reset for eight cycles, then run each scenario.
   initial
   begin
      repeat (8) @(posedge ref_clk);
      #1;
      resetn = 1'b1;
      t_reset();
      t_good();
      t_link();
      t_under();
      t_misc();
      summarize();
   end
endmodule
